/* core/mpo_pkg.sv */
// Shared constants and types for the monitor PWM/pulse output block, plus its divider.
package mpo_pkg;
    // Clock and timing.
    localparam longint CLK_HZ = 64'd100000000;
    localparam longint PWM_PERIOD_NS = 64'd6400000;
    localparam longint PWM_PERIOD_CYCLES = PWM_PERIOD_NS * CLK_HZ / 64'd1000000000;
    localparam longint MAX_PULSE_HZ = 64'd32000;
    localparam longint MIN_HALF_CYCLES = (CLK_HZ + 2 * MAX_PULSE_HZ - 1) / (2 * MAX_PULSE_HZ);
    localparam longint HALF_LIMIT_CYCLES = 64'd4294967295;
    // Half period in cycles is HALF_NUM divided by the frequency in units of 0.01 Hz.
    localparam longint HALF_NUM = CLK_HZ * 100 / 2;
    localparam longint REF_PULSE_CHZ = 64'd144000;
    localparam longint CUR_DEN_FACTOR = REF_PULSE_CHZ / 10;
    localparam longint PCT = 64'd100;
    // Full-scale values of the PWM sources, in the units of their input ports.
    localparam longint FS_CURRENT = 64'd2000;
    localparam longint FS_TORQUE = 64'd2000;
    localparam longint FS_VOLTAGE = 64'd1330;
    localparam longint FS_POWER = 64'd2000;
    localparam longint FS_THERMAL = 64'd1000;
    localparam longint FS_TEMP = 64'd2000;
    localparam longint FS_GENERAL = 64'd1000;
    // Setting ranges.
    localparam logic [7:0] GAIN_MIN = 8'h32;
    localparam logic [7:0] GAIN_MAX = 8'hc8;
    localparam logic [7:0] REF_MIN = 8'h14;
    localparam logic [7:0] REF_MAX = 8'hc8;
    localparam logic [13:0] SCALE_MIN = 14'h0001;
    localparam logic [13:0] SCALE_MAX = 14'h270f;
    // Datapath widths.
    localparam int NUM_W = 48;
    localparam int DEN_W = 40;
    localparam int CNT_W = 34;

    typedef enum logic [4:0] {
        SRC_OUT_FREQ = 5'h00,
        SRC_CURRENT = 5'h01,
        SRC_TORQUE = 5'h02,
        SRC_DIG_FREQ = 5'h03,
        SRC_VOLTAGE = 5'h04,
        SRC_POWER = 5'h05,
        SRC_THERMAL = 5'h06,
        SRC_RAMP_FREQ = 5'h07,
        SRC_DIG_CURRENT = 5'h08,
        SRC_FIN_TEMP = 5'h0a,
        SRC_GENERAL = 5'h0c,
        SRC_PULSE_IN = 5'h0f,
        SRC_OPTION = 5'h10
    } mpo_src_t;

    typedef enum logic [0:0] {
        CALC_IDLE = 1'b0,
        CALC_RUN = 1'b1
    } mpo_calc_t;
endpackage : mpo_pkg

`timescale 1ns/10ps
module mpo_divider #(
    parameter int NW = 48,
    parameter int DW = 40
) (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Request.
    input wire logic start_in,
    input wire logic [NW-1:0] num_in,
    input wire logic [DW-1:0] den_in,
    // Answer.
    output logic busy_out,
    output logic done_out,
    output logic [NW-1:0] quot_out
);
    logic [NW-1:0] quot_reg, quot_next;
    logic [DW:0] rem_reg, rem_next;
    logic [DW-1:0] den_reg, den_next;
    logic [7:0] step_reg, step_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [DW:0] trial;

    // Restoring division, one quotient bit per cycle; a zero divisor yields all ones.
    always_comb begin
        quot_next = quot_reg;
        rem_next = rem_reg;
        den_next = den_reg;
        step_next = step_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        trial = '0;
        if (start_in && !busy_reg) begin
            quot_next = num_in;
            rem_next = '0;
            den_next = den_in;
            step_next = 8'(NW);
            busy_next = 1'b1;
        end else if (busy_reg) begin
            trial = {rem_reg[DW-1:0], quot_reg[NW-1]};
            quot_next = {quot_reg[NW-2:0], 1'b0};
            if (trial >= {1'b0, den_reg}) begin
                rem_next = trial - {1'b0, den_reg};
                quot_next[0] = 1'b1;
            end else begin
                rem_next = trial;
            end
            step_next = step_reg - 8'h01;
            if (step_reg == 8'h01) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            quot_reg <= '0;
            rem_reg <= '0;
            den_reg <= '0;
            step_reg <= 8'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            quot_reg <= quot_next;
            rem_reg <= rem_next;
            den_reg <= den_next;
            step_reg <= step_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign busy_out = busy_reg;
    assign done_out = done_reg;
    assign quot_out = quot_reg;
endmodule : mpo_divider

/* core/mpo_monitor_pwm_pulse_output.sv */
// Digital monitor output: one monitored quantity as fixed-period PWM or as a 50 percent pulse train.
//
// Functional notes
// - PWM mode has a constant 6.4 ms period; high time encodes the value.
// - Pulse mode varies the period; high time is half the period, or zero (terminal held low) at zero frequency.
// - Pulse frequency never exceeds 32 kHz.
// - Source select codes 00 to 16 choose the monitored quantity.
// - Codes 00-02, 04-07, 10, 12 are PWM and use the PWM gain.
// - PWM gain of 50 to 200 percent multiplies the duty.
// - Code 08 gives pulses proportional to current; reference current gives 1,440 Hz.
// - Current reference 0.20 to 2.00 times rated sets the 1,440 Hz point.
// - Code 15 outputs input pulse frequency times scale gain 0.01 to 99.99.
// - Code 03 tracks output frequency, converted when a conversion gain is set.
// - Output frequency at maximum frequency gives full duty at 100 percent gain.
// - Current full scale is 200 percent of rated current.
// - Fin temperature 0 to 200 C is full scale; below zero gives zero.
// - Output voltage 0 to 133 percent of nominal is full scale.
// - Code 06 maps thermal load 0 to 100 percent onto full scale.
// - Torque output is meaningful only under sensorless vector control.
// - Code 07 outputs commanded ramp frequency, full scale maximum frequency.
`timescale 1ns/10ps
module mpo_monitor_pwm_pulse_output
    import mpo_pkg::*;
#(
    parameter logic [CNT_W-1:0] PWM_CYCLES = CNT_W'(PWM_PERIOD_CYCLES)
) (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Settings.
    input wire logic [4:0] monitor_source_select_in,
    input wire logic [7:0] pwm_gain_setting_in,
    input wire logic [7:0] current_pulse_reference_in,
    input wire logic [13:0] pulse_scale_gain_in,
    input wire logic [15:0] frequency_conversion_gain_in,
    input wire logic sensorless_vector_in,
    // Monitored quantities.
    input wire logic [15:0] output_freq_in,
    input wire logic [15:0] commanded_ramp_frequency_in,
    input wire logic [15:0] max_freq_in,
    input wire logic [15:0] output_current_in,
    input wire logic [15:0] output_torque_in,
    input wire logic [15:0] output_voltage_in,
    input wire logic [15:0] input_power_in,
    input wire logic [15:0] thermal_load_in,
    input wire logic signed [15:0] fin_temp_in,
    input wire logic [15:0] general_analog_in,
    input wire logic [19:0] input_pulse_freq_in,
    // Terminal and status.
    output logic digital_monitor_terminal_out,
    output logic pulse_mode_out,
    output logic [4:0] active_source_out
);
    localparam logic [NUM_W-1:0] HALF_MIN = NUM_W'(MIN_HALF_CYCLES);
    localparam logic [NUM_W-1:0] HALF_MAX = NUM_W'(HALF_LIMIT_CYCLES);

    function automatic logic [15:0] clamp16(input logic [15:0] x, input logic [15:0] lo, input logic [15:0] hi);
        clamp16 = (x < lo) ? lo : ((x > hi) ? hi : x);
    endfunction : clamp16

    // Duty numerator: value times gain times period cycles; divided later by full scale times 100.
    function automatic logic [NUM_W-1:0] duty_num(input logic [15:0] value, input logic [7:0] gain);
        duty_num = NUM_W'(value) * NUM_W'(gain) * NUM_W'(PWM_CYCLES);
    endfunction : duty_num

    function automatic logic [DEN_W-1:0] duty_den(input longint full_scale);
        duty_den = DEN_W'(full_scale * PCT);
    endfunction : duty_den

    // Calculation state.
    mpo_calc_t calc_reg, calc_next;
    logic calc_pulse_reg, calc_pulse_next;
    logic calc_zero_reg, calc_zero_next;
    logic [4:0] calc_src_reg, calc_src_next;
    // Pending values, applied at the next boundary.
    logic pend_pulse_reg, pend_pulse_next;
    logic [4:0] pend_src_reg, pend_src_next;
    logic [CNT_W-1:0] pend_period_reg, pend_period_next;
    logic [CNT_W-1:0] pend_high_reg, pend_high_next;
    // Live waveform.
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] period_reg, period_next;
    logic [CNT_W-1:0] high_reg, high_next;
    logic mode_reg, mode_next;
    logic [4:0] src_reg, src_next;
    logic term_reg, term_next;

    // Source decode results.
    logic sel_pulse;
    logic [NUM_W-1:0] sel_num;
    logic [DEN_W-1:0] sel_den;
    logic [7:0] gain;
    logic [7:0] cur_ref;
    logic [13:0] scale;
    logic [15:0] temp_pos;

    // Divider.
    logic div_start;
    logic div_busy;
    logic div_done;
    logic [NUM_W-1:0] div_quot;
    logic [NUM_W-1:0] half_clamped;

    mpo_divider #(
        .NW(NUM_W),
        .DW(DEN_W)
    ) u_div (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .start_in(div_start),
        .num_in(sel_num),
        .den_in(sel_den),
        .busy_out(div_busy),
        .done_out(div_done),
        .quot_out(div_quot)
    );

    // Decode the selected source into one division: duty cycles or half-period cycles.
    always_comb begin
        gain = 8'(clamp16({8'h00, pwm_gain_setting_in}, {8'h00, GAIN_MIN}, {8'h00, GAIN_MAX}));
        cur_ref = 8'(clamp16({8'h00, current_pulse_reference_in}, {8'h00, REF_MIN}, {8'h00, REF_MAX}));
        scale = 14'(clamp16({2'b00, pulse_scale_gain_in}, {2'b00, SCALE_MIN}, {2'b00, SCALE_MAX}));
        temp_pos = fin_temp_in[15] ? 16'h0000 : fin_temp_in;
        sel_pulse = 1'b0;
        sel_num = '0;
        sel_den = duty_den(FS_GENERAL);
        case (monitor_source_select_in)
            SRC_OUT_FREQ: begin
                sel_num = duty_num(output_freq_in, gain);
                sel_den = DEN_W'(max_freq_in) * DEN_W'(PCT);
            end
            SRC_CURRENT: begin
                sel_num = duty_num(output_current_in, gain);
                sel_den = duty_den(FS_CURRENT);
            end
            SRC_TORQUE: begin
                sel_num = sensorless_vector_in ? duty_num(output_torque_in, gain) : '0;
                sel_den = duty_den(FS_TORQUE);
            end
            SRC_DIG_FREQ: begin
                sel_pulse = 1'b1;
                if (frequency_conversion_gain_in != 16'h0000) begin
                    sel_num = NUM_W'(HALF_NUM * PCT);
                    sel_den = DEN_W'(output_freq_in) * DEN_W'(frequency_conversion_gain_in);
                end else begin
                    sel_num = NUM_W'(HALF_NUM);
                    sel_den = DEN_W'(output_freq_in);
                end
            end
            SRC_VOLTAGE: begin
                sel_num = duty_num(output_voltage_in, gain);
                sel_den = duty_den(FS_VOLTAGE);
            end
            SRC_POWER: begin
                sel_num = duty_num(input_power_in, gain);
                sel_den = duty_den(FS_POWER);
            end
            SRC_THERMAL: begin
                sel_num = duty_num(thermal_load_in, gain);
                sel_den = duty_den(FS_THERMAL);
            end
            SRC_RAMP_FREQ: begin
                sel_num = duty_num(commanded_ramp_frequency_in, gain);
                sel_den = DEN_W'(max_freq_in) * DEN_W'(PCT);
            end
            SRC_DIG_CURRENT: begin
                sel_pulse = 1'b1;
                sel_num = NUM_W'(HALF_NUM) * NUM_W'(cur_ref);
                sel_den = DEN_W'(output_current_in) * DEN_W'(CUR_DEN_FACTOR);
            end
            SRC_FIN_TEMP: begin
                sel_num = duty_num(temp_pos, gain);
                sel_den = duty_den(FS_TEMP);
            end
            SRC_GENERAL: begin
                sel_num = duty_num(general_analog_in, gain);
                sel_den = duty_den(FS_GENERAL);
            end
            SRC_PULSE_IN: begin
                sel_pulse = 1'b1;
                sel_num = NUM_W'(HALF_NUM);
                sel_den = DEN_W'(input_pulse_freq_in) * DEN_W'(scale);
            end
            default: begin
                // Option and unlisted codes: PWM with zero duty.
                sel_num = '0;
                sel_den = duty_den(FS_GENERAL);
            end
        endcase
    end

    // Recalculate continuously; each finished result becomes the pending waveform.
    always_comb begin
        calc_next = calc_reg;
        calc_pulse_next = calc_pulse_reg;
        calc_zero_next = calc_zero_reg;
        calc_src_next = calc_src_reg;
        pend_pulse_next = pend_pulse_reg;
        pend_src_next = pend_src_reg;
        pend_period_next = pend_period_reg;
        pend_high_next = pend_high_reg;
        div_start = 1'b0;
        // Shorter than the minimum half period means the frequency is too high.
        half_clamped = (div_quot < HALF_MIN) ? HALF_MIN : ((div_quot > HALF_MAX) ? HALF_MAX : div_quot);
        unique case (calc_reg)
            CALC_IDLE: begin
                div_start = 1'b1;
                calc_pulse_next = sel_pulse;
                calc_zero_next = (sel_den == '0);
                calc_src_next = monitor_source_select_in;
                calc_next = CALC_RUN;
            end
            CALC_RUN: begin
                if (div_done) begin
                    calc_next = CALC_IDLE;
                    pend_pulse_next = calc_pulse_reg;
                    pend_src_next = calc_src_reg;
                    if (!calc_pulse_reg) begin
                        pend_period_next = PWM_CYCLES;
                        if (calc_zero_reg) begin
                            pend_high_next = '0;
                        end else if (div_quot > NUM_W'(PWM_CYCLES)) begin
                            pend_high_next = PWM_CYCLES;
                        end else begin
                            pend_high_next = CNT_W'(div_quot);
                        end
                    end else if (calc_zero_reg) begin
                        // Zero frequency: hold the terminal low, still ticking boundaries.
                        pend_period_next = CNT_W'(2 * MIN_HALF_CYCLES);
                        pend_high_next = '0;
                    end else begin
                        pend_period_next = CNT_W'({half_clamped, 1'b0});
                        pend_high_next = CNT_W'(half_clamped);
                    end
                end
            end
        endcase
    end

    // Waveform counter; new settings load only when a period completes.
    always_comb begin
        cnt_next = cnt_reg + CNT_W'(1);
        period_next = period_reg;
        high_next = high_reg;
        mode_next = mode_reg;
        src_next = src_reg;
        if (cnt_reg >= period_reg - CNT_W'(1)) begin
            cnt_next = '0;
            period_next = pend_period_reg;
            high_next = pend_high_reg;
            mode_next = pend_pulse_reg;
            src_next = pend_src_reg;
        end
        term_next = (cnt_next < high_next);
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            calc_reg <= CALC_IDLE;
            calc_pulse_reg <= 1'b0;
            calc_zero_reg <= 1'b0;
            calc_src_reg <= 5'h00;
            pend_pulse_reg <= 1'b0;
            pend_src_reg <= 5'h00;
            pend_period_reg <= PWM_CYCLES;
            pend_high_reg <= '0;
            cnt_reg <= '0;
            period_reg <= PWM_CYCLES;
            high_reg <= '0;
            mode_reg <= 1'b0;
            src_reg <= 5'h00;
            term_reg <= 1'b0;
        end else begin
            calc_reg <= calc_next;
            calc_pulse_reg <= calc_pulse_next;
            calc_zero_reg <= calc_zero_next;
            calc_src_reg <= calc_src_next;
            pend_pulse_reg <= pend_pulse_next;
            pend_src_reg <= pend_src_next;
            pend_period_reg <= pend_period_next;
            pend_high_reg <= pend_high_next;
            cnt_reg <= cnt_next;
            period_reg <= period_next;
            high_reg <= high_next;
            mode_reg <= mode_next;
            src_reg <= src_next;
            term_reg <= term_next;
        end
    end

    assign digital_monitor_terminal_out = term_reg;
    assign pulse_mode_out = mode_reg;
    assign active_source_out = src_reg;
endmodule : mpo_monitor_pwm_pulse_output

/* sim/mpo_checker.sv */
// Concurrent checks on the monitor terminal and its status ports.
`timescale 1ns/10ps
module mpo_checker
    import mpo_pkg::*;
#(
    parameter logic [CNT_W-1:0] PWM_CYCLES = 34'h0009c400
) (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Watched outputs.
    input wire logic digital_monitor_terminal_out,
    input wire logic pulse_mode_out,
    input wire logic [4:0] active_source_out
);
    logic [CNT_W-1:0] hi_reg, hi_next, lo_reg, lo_next, last_hi_reg, last_hi_next, since_reg, since_next;
    logic prev_reg, clean_reg, clean_next, seen_reg, seen_next, rise;

    // Run lengths are kept here because a repetition count cannot reach a whole period.
    always_comb begin
        rise = digital_monitor_terminal_out && !prev_reg;
        hi_next = digital_monitor_terminal_out ? hi_reg + 1'b1 : '0;
        lo_next = digital_monitor_terminal_out ? '0 : lo_reg + 1'b1;
        last_hi_next = (!digital_monitor_terminal_out && hi_reg != '0) ? hi_reg : last_hi_reg;
        since_next = rise ? CNT_W'(1) : since_reg + 1'b1;
        clean_next = (rise ? 1'b1 : clean_reg) && !pulse_mode_out;
        seen_next = seen_reg || rise;
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            {hi_reg, lo_reg, last_hi_reg, since_reg} <= '0;
            {prev_reg, clean_reg, seen_reg} <= '0;
        end else begin
            {hi_reg, lo_reg, last_hi_reg, since_reg} <= {hi_next, lo_next, last_hi_next, since_next};
            {prev_reg, clean_reg, seen_reg} <= {digital_monitor_terminal_out, clean_next, seen_next};
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_low8;
        !digital_monitor_terminal_out [*8];
    endsequence
    sequence s_src_hold8;
        $stable(active_source_out) [*8];
    endsequence

    reset_low_a: assert property ($rose(rst_b_in) |-> s_low8)
        else $error("terminal not low after reset");
    pwm_period_a: assert property ($rose(digital_monitor_terminal_out) && clean_reg && seen_reg
        |-> (since_reg % PWM_CYCLES) == '0) else $error("pwm rise off the period grid");
    mode_map_a: assert property (pulse_mode_out == (active_source_out inside {5'h03, 5'h08, 5'h0f}))
        else $error("output mode does not match source");
    mode_source_a: assert property ($changed(pulse_mode_out) |-> $changed(active_source_out))
        else $error("mode changed without a source change");
    source_hold_a: assert property ($changed(active_source_out) |=> s_src_hold8)
        else $error("source changed inside a period");
    pulse_half_a: assert property ($rose(digital_monitor_terminal_out) && $past(pulse_mode_out)
        |-> lo_reg == last_hi_reg) else $error("pulse low time differs from high time");
    pulse_max_a: assert property ($fell(digital_monitor_terminal_out) && pulse_mode_out && $past(pulse_mode_out)
        |-> hi_reg >= MIN_HALF_CYCLES) else $error("pulse frequency above terminal limit");
    bad_code_a: assert property ((active_source_out inside {5'h09, 5'h0b, 5'h0d, 5'h0e} ||
        active_source_out >= 5'h10) |-> !digital_monitor_terminal_out) else $error("unused code drives terminal");
endmodule : mpo_checker

/* sim/mpo_meter.sv */
// Far-side meter: counts rises, period, high time and total high cycles of the terminal.
`timescale 1ns/10ps
module mpo_meter (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Watched terminal.
    input wire logic sig_in,
    // Readings.
    output logic [31:0] rises_out,
    output logic [33:0] period_out,
    output logic [33:0] high_out,
    output logic [33:0] hi_total_out
);
    logic prev_reg;
    logic [33:0] since_reg;
    logic [33:0] hi_reg;

    // Sampling on the block clock gives exact cycle counts, which a real counter would only approximate.
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            {prev_reg, since_reg, hi_reg, rises_out, period_out, high_out, hi_total_out} <= '0;
        end else begin
            prev_reg <= sig_in;
            since_reg <= (sig_in && !prev_reg) ? 34'h1 : since_reg + 34'h1;
            hi_reg <= sig_in ? hi_reg + 34'h1 : 34'h0;
            hi_total_out <= hi_total_out + {33'h0, sig_in};
            if (sig_in && !prev_reg) begin
                rises_out <= rises_out + 32'h1;
                period_out <= since_reg;
            end
            if (!sig_in && prev_reg) begin
                high_out <= hi_reg;
            end
        end
    end
endmodule : mpo_meter

/* sim/tb_monitor_pwm_pulse_output.sv */
// Self-checking bench for the monitor PWM and pulse output block.
`timescale 1ns/10ps
module tb_monitor_pwm_pulse_output;
    // A short PWM period keeps the run small; every duty expectation scales with it.
    localparam logic [33:0] PWM_C = 34'h3e8;
    logic clk_sys_in, rst_b_in, sv, term, pmode;
    logic [4:0] sel, asrc;
    logic [7:0] gain, cref;
    logic [13:0] scale;
    logic [15:0] conv, of, ramp, maxf, cur, trq, volt, pwr, therm, gen;
    logic signed [15:0] fin;
    logic [19:0] pin;
    logic [31:0] rises;
    logic [33:0] per, hi, hitot;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [4:0] codes [9] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0a, 5'h0c};
    logic [33:0] exps [9] = '{34'hfa, 34'h1f4, 34'h1f4, 34'h1f4, 34'hfa, 34'hfa, 34'h1f4, 34'hfa, 34'hfa};

    mpo_monitor_pwm_pulse_output #(.PWM_CYCLES(PWM_C)) dut (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .monitor_source_select_in(sel), .pwm_gain_setting_in(gain),
        .current_pulse_reference_in(cref), .pulse_scale_gain_in(scale),
        .frequency_conversion_gain_in(conv), .sensorless_vector_in(sv),
        .output_freq_in(of), .commanded_ramp_frequency_in(ramp), .max_freq_in(maxf),
        .output_current_in(cur), .output_torque_in(trq), .output_voltage_in(volt),
        .input_power_in(pwr), .thermal_load_in(therm), .fin_temp_in(fin),
        .general_analog_in(gen), .input_pulse_freq_in(pin),
        .digital_monitor_terminal_out(term), .pulse_mode_out(pmode), .active_source_out(asrc));

    mpo_meter meter (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .sig_in(term),
        .rises_out(rises), .period_out(per), .high_out(hi), .hi_total_out(hitot));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check

    // Whole periods in the window make the high count independent of phase.
    task automatic pwm_case(input logic [4:0] code, input logic [7:0] g, input logic [33:0] exp_hi);
        logic [33:0] t0;
        @(negedge clk_sys_in);
        sel = code;
        gain = g;
        repeat (110 + PWM_C) @(negedge clk_sys_in);
        t0 = hitot;
        repeat (PWM_C) @(negedge clk_sys_in);
        check("pwm high cycles", hitot - t0, exp_hi);
        check("pulse mode flag", pmode, 1'b0);
        check("active source", asrc, code);
    endtask : pwm_case

    task automatic pulse_case(input logic [4:0] code, input logic [33:0] half);
        int n;
        logic [31:0] r0;
        @(negedge clk_sys_in);
        sel = code;
        repeat (110) @(negedge clk_sys_in);
        r0 = rises;
        n = 0;
        // The first rise opens the new waveform, so the second one closes a full new period.
        while (rises - r0 < 32'd2 && n < 40000) begin
            @(negedge clk_sys_in);
            n++;
        end
        check("pulse period", per, 2 * half);
        check("pulse high", hi, half);
        check("pulse mode flag", pmode, 1'b1);
        check("active source", asrc, code);
    endtask : pulse_case

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 100000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    initial begin
        {rst_b_in, sel, conv, pin} = '0;
        {gain, cref, scale, sv} = {8'h64, 8'h64, 14'h0064, 1'b1};
        {of, ramp, maxf, cur, trq} = {16'h05dc, 16'h0bb8, 16'h1770, 16'h03e8, 16'h03e8};
        {volt, pwr, therm, fin, gen} = {16'h0299, 16'h01f4, 16'h00fa, 16'h01f4, 16'h00fa};
        repeat (8) @(negedge clk_sys_in);
        check("terminal in reset", term, 1'b0);
        check("source in reset", asrc, 5'h00);
        rst_b_in = 1'b1;
        for (int i = 0; i < 9; i++) begin
            pwm_case(codes[i], 8'h64, exps[i]);
        end
        check("pwm period", per, PWM_C);
        check("pwm high", hi, 34'hfa);
        pwm_case(5'h01, 8'hc8, 34'h3e8);
        pwm_case(5'h01, 8'h96, 34'h2ee);
        pwm_case(5'h01, 8'h0a, 34'hfa);
        cur = 16'h05dc;
        pwm_case(5'h01, 8'hc8, 34'h3e8);
        of = 16'h1770;
        pwm_case(5'h00, 8'h64, 34'h3e8);
        sv = 1'b0;
        pwm_case(5'h02, 8'h64, 34'h0);
        fin = 16'hff9c;
        pwm_case(5'h0a, 8'h64, 34'h0);
        pwm_case(5'h09, 8'h64, 34'h0);
        pwm_case(5'h10, 8'h64, 34'h0);
        {pin, scale} = {20'h01f40, 14'h00fa};
        pulse_case(5'h0f, 34'h9c4);
        {pin, scale} = {20'h04e20, 14'h3fff};
        pulse_case(5'h0f, 34'h61b);
        cur = 16'h3e80;
        pulse_case(5'h08, 34'h87a);
        {cur, cref} = {16'h07d0, 8'h05};
        pulse_case(5'h08, 34'hd90);
        {of, conv} = {16'hea60, 16'h0fa0};
        pulse_case(5'h03, 34'h823);
        tally_and_finish();
    end
endmodule : tb_monitor_pwm_pulse_output

bind mpo_monitor_pwm_pulse_output mpo_checker #(.PWM_CYCLES(PWM_CYCLES)) u_checker (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .digital_monitor_terminal_out(digital_monitor_terminal_out),
    .pulse_mode_out(pulse_mode_out), .active_source_out(active_source_out));
